// ===== rtl/ovs_setpoint_bank.sv
`default_nettype none
module ovs_setpoint_bank (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] strap_voltage_i,
  input  wire logic [7:0]  operation_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [1:0]  cmd_bytes_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             rsp_valid_o,
  output logic             rsp_err_o,
  output logic      [15:0] rsp_data_o,
  output logic      [15:0] vout_ref_o,
  output logic             unit_on_o,
  output logic             ramp_busy_o,
  output logic             init_done_o
);
  import ovs_pkg::*;

  logic [15:0] target_voltage_setpoint;
  logic [15:0] voltage_calibration_offset;
  logic [15:0] voltage_upper_limit;
  logic [15:0] margin_high_setpoint;
  logic [15:0] margin_low_setpoint;
  logic [15:0] margin_slew_rate;

  logic [15:0] strap_meta;
  logic [15:0] strap_sync;
  logic [1:0]  init_cnt;
  logic        init_load;
  logic [15:0] dflt_high;
  logic [15:0] dflt_low;
  logic [15:0] dflt_limit;

  // strap crosses in from pins, so two flops before use
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strap_meta <= 16'h0000;
      strap_sync <= 16'h0000;
    end else begin
      strap_meta <= strap_voltage_i;
      strap_sync <= strap_meta;
    end
  end

  // wait until the synchroniser has filled before trusting the strap
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt    <= 2'h0;
      init_done_o <= 1'b0;
    end else if (!init_done_o) begin
      init_cnt    <= init_cnt + 2'h1;
      init_done_o <= init_load;
    end
  end
  assign init_load = !init_done_o && (init_cnt == INIT_WAIT_CYCLES);

  ovs_scale #(.NUM(RATIO_MARGIN_HIGH)) u_scale_high (
    .value_i  (strap_sync),
    .scaled_o (dflt_high)
  );
  ovs_scale #(.NUM(RATIO_MARGIN_LOW)) u_scale_low (
    .value_i  (strap_sync),
    .scaled_o (dflt_low)
  );
  ovs_scale #(.NUM(RATIO_UPPER_LIMIT)) u_scale_limit (
    .value_i  (strap_sync),
    .scaled_o (dflt_limit)
  );

  // command decode
  logic known_word;
  logic is_mode;
  logic len_ok;
  logic wr_ok;
  always_comb begin
    known_word = 1'b0;
    case (cmd_code_i)
      CMD_TARGET_SETPT, CMD_CAL_OFFSET, CMD_UPPER_LIMIT,
      CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_SLEW_RATE: known_word = 1'b1;
      default: known_word = 1'b0;
    endcase
  end
  assign is_mode = (cmd_code_i == CMD_VOLTAGE_MODE);
  // word commands take two bytes, the mode byte one and is never writable
  assign len_ok = known_word ? (cmd_bytes_i == WORD_BYTES)
                : (is_mode && !cmd_write_i && cmd_bytes_i == BYTE_BYTES);
  assign wr_ok  = cmd_valid_i && cmd_write_i && known_word && len_ok && init_done_o;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      target_voltage_setpoint <= SETPOINT_RST;
      voltage_upper_limit     <= SETPOINT_RST;
      margin_high_setpoint    <= SETPOINT_RST;
      margin_low_setpoint     <= SETPOINT_RST;
    end else if (init_load) begin
      target_voltage_setpoint <= strap_sync;
      margin_high_setpoint    <= dflt_high;
      margin_low_setpoint     <= dflt_low;
      voltage_upper_limit     <= dflt_limit;
    end else if (wr_ok) begin
      case (cmd_code_i)
        CMD_TARGET_SETPT: target_voltage_setpoint <= cmd_wdata_i;
        CMD_UPPER_LIMIT:  voltage_upper_limit     <= cmd_wdata_i;
        CMD_MARGIN_HIGH:  margin_high_setpoint    <= cmd_wdata_i;
        CMD_MARGIN_LOW:   margin_low_setpoint     <= cmd_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      voltage_calibration_offset <= CAL_OFFSET_RST;
      margin_slew_rate           <= SLEW_RATE_RST;
    end else if (wr_ok && cmd_code_i == CMD_CAL_OFFSET) begin
      voltage_calibration_offset <= cmd_wdata_i;
    end else if (wr_ok && cmd_code_i == CMD_SLEW_RATE) begin
      margin_slew_rate <= cmd_wdata_i;
    end
  end

  // read path, answer one cycle after the request
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    case (cmd_code_i)
      CMD_VOLTAGE_MODE: rd_word = VOLTAGE_MODE_VAL;
      CMD_TARGET_SETPT: rd_word = target_voltage_setpoint;
      CMD_CAL_OFFSET:   rd_word = voltage_calibration_offset;
      CMD_UPPER_LIMIT:  rd_word = voltage_upper_limit;
      CMD_MARGIN_HIGH:  rd_word = margin_high_setpoint;
      CMD_MARGIN_LOW:   rd_word = margin_low_setpoint;
      CMD_SLEW_RATE:    rd_word = margin_slew_rate;
      default:          rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_err_o   <= 1'b0;
      rsp_data_o  <= 16'h0000;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_err_o   <= cmd_valid_i && !(len_ok && init_done_o);
      rsp_data_o  <= (cmd_valid_i && !cmd_write_i && len_ok && init_done_o) ? rd_word : 16'h0000;
    end
  end

  // operation decode
  logic       unit_on;
  logic [1:0] margin_sel;
  assign unit_on    = (operation_i[7:6] == OP_UNIT_ON) && init_done_o;
  assign margin_sel = operation_i[5:4];

  // effective target: selected set point plus signed offset, limited
  logic [15:0]        sel_sp;
  logic signed [17:0] sum_sp;
  logic [15:0]        next_eff;
  always_comb begin
    case (margin_sel)
      OP_MARGIN_HIGH: sel_sp = margin_high_setpoint;
      OP_MARGIN_LOW:  sel_sp = margin_low_setpoint;
      default:        sel_sp = target_voltage_setpoint;
    endcase
    sum_sp = $signed({2'b00, sel_sp}) + 18'(signed'(voltage_calibration_offset));
    if (!unit_on) begin
      next_eff = 16'h0000;
    end else if (sum_sp < 18'sd0) begin
      next_eff = 16'h0000;
    end else if (sum_sp > $signed({2'b00, voltage_upper_limit})) begin
      next_eff = voltage_upper_limit;
    end else begin
      next_eff = sum_sp[15:0];
    end
  end

  // a margin change ramps, as does any change made before that ramp ends; anything else steps
  logic [15:0] eff_target;
  logic [1:0]  margin_q;
  logic        jump_q;
  logic        ramp_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      eff_target <= 16'h0000;
      margin_q   <= OP_MARGIN_NONE;
      unit_on_o  <= 1'b0;
      jump_q     <= 1'b0;
      ramp_q     <= 1'b0;
    end else begin
      eff_target <= next_eff;
      margin_q   <= margin_sel;
      unit_on_o  <= unit_on;
      jump_q     <= unit_on != unit_on_o;
      if (unit_on != unit_on_o || !unit_on) begin
        ramp_q <= 1'b0;
      end else if (margin_sel != margin_q) begin
        ramp_q <= 1'b1;
      end else if (!busy) begin
        ramp_q <= 1'b0;  // a finished ramp lets later writes step
      end
    end
  end

  // linear-11 rate to a q16 step per microsecond
  logic signed [4:0]  rate_exp;
  logic signed [10:0] rate_man;
  logic               rate_fast;
  logic [47:0]        rate_prod;
  logic signed [6:0]  rate_sh;
  logic [47:0]        rate_wide;
  logic [31:0]        step_q;
  assign rate_exp  = margin_slew_rate[15:11];
  assign rate_man  = margin_slew_rate[10:0];
  // a zero or negative rate cannot be served; it is treated as immediate
  assign rate_fast = (margin_slew_rate == SLEW_RATE_FASTEST) || (rate_man <= 11'sd0);
  assign rate_prod = 48'(rate_man[9:0]) * 48'(LSB_PER_VUS_NUM);
  assign rate_sh   = 7'(rate_exp) + 7'(RATE_Q_SHIFT);
  assign rate_wide = (rate_sh >= 7'sd0) ? (rate_prod << rate_sh) : (rate_prod >> (-rate_sh));

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= 32'h0000_0000;
    end else begin
      step_q <= (rate_wide[47:32] != 16'h0000) ? 32'hffff_ffff : rate_wide[31:0];
    end
  end

  // microsecond tick
  logic [7:0] tick_cnt;
  logic       tick;
  assign tick = (tick_cnt == 8'(SLEW_TICK_CYCLES - 1));
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  logic [15:0] level;
  logic        busy;
  ovs_slew u_slew (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .target_i(eff_target),
    .jump_i  (jump_q || rate_fast),
    .ramp_i  (ramp_q),
    .tick_i  (tick),
    .step_i  (step_q),
    .level_o (level),
    .busy_o  (busy)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vout_ref_o  <= 16'h0000;
      ramp_busy_o <= 1'b0;
    end else begin
      vout_ref_o  <= level;
      ramp_busy_o <= ramp_q && busy;
    end
  end

  a_rsp_one_cycle: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_valid_i |=> rsp_valid_o) else $error("no answer one cycle after request");
  a_short_word_err: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_valid_i && known_word && cmd_bytes_i != 2'h2) |=> rsp_err_o)
    else $error("wrong length word not refused");
  a_mode_read_val: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_valid_i && !cmd_write_i && cmd_code_i == 8'h20 && cmd_bytes_i == 2'h1 && init_done_o)
    |=> rsp_data_o == 16'h0013) else $error("mode byte wrong");
  a_target_write_back: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_ok && cmd_code_i == 8'h21) |=> target_voltage_setpoint == $past(cmd_wdata_i))
    else $error("target write not stored");
  a_strap_load_target: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(init_done_o) |-> target_voltage_setpoint == $past(strap_sync))
    else $error("target not taken from strap");
  a_cal_rate_reset: assert property (@(posedge clock_i) disable iff (rst_i)
    !init_done_o |-> voltage_calibration_offset == 16'h0000 && margin_slew_rate == 16'hba00)
    else $error("offset or rate reset value wrong");
  a_limit_bound: assert property (@(posedge clock_i) disable iff (rst_i)
    init_done_o |=> eff_target <= $past(voltage_upper_limit))
    else $error("target exceeds upper limit");
  a_margin_high_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    (unit_on && margin_sel == 2'h2 && voltage_calibration_offset == 16'h0000
     && margin_high_setpoint <= voltage_upper_limit) |=> eff_target == $past(margin_high_setpoint))
    else $error("margin high not selected");
  a_fast_no_ramp: assert property (@(posedge clock_i) disable iff (rst_i)
    (rate_fast && $stable(eff_target)) |=> ##1 vout_ref_o == $past(eff_target, 2))
    else $error("fastest rate still ramped");
  a_off_step_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    ($fell(unit_on) ##1 !unit_on) |=> ##1 vout_ref_o == 16'h0000)
    else $error("turn-off was rate limited");

  c_margin_ramp: cover property (@(posedge clock_i) disable iff (rst_i) $rose(ramp_busy_o));
  c_clamped: cover property (@(posedge clock_i) disable iff (rst_i)
    unit_on && next_eff == voltage_upper_limit && sum_sp > $signed({2'b00, voltage_upper_limit}));
  c_write_read: cover property (@(posedge clock_i) disable iff (rst_i)
    wr_ok ##1 (cmd_valid_i && !cmd_write_i && len_ok));
endmodule
`default_nettype wire

// ===== rtl/ovs_pkg.sv
`default_nettype none
package ovs_pkg;
  // command codes of the set-point bank
  localparam logic [7:0] CMD_VOLTAGE_MODE   = 8'h20;
  localparam logic [7:0] CMD_TARGET_SETPT   = 8'h21;
  localparam logic [7:0] CMD_CAL_OFFSET     = 8'h23;
  localparam logic [7:0] CMD_UPPER_LIMIT    = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH    = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW     = 8'h26;
  localparam logic [7:0] CMD_SLEW_RATE      = 8'h27;
  // linear mode, exponent -13
  localparam logic [15:0] VOLTAGE_MODE_VAL  = 16'h0013;
  localparam logic [1:0]  WORD_BYTES        = 2'h2;
  localparam logic [1:0]  BYTE_BYTES        = 2'h1;
  localparam logic [15:0] CAL_OFFSET_RST    = 16'h0000;
  localparam logic [15:0] SLEW_RATE_RST     = 16'hba00;
  localparam logic [15:0] SLEW_RATE_FASTEST = 16'h7bff;
  localparam logic [15:0] SETPOINT_RST      = 16'h0000;
  // strap ratios as n/100; the scaled defaults are truncated, not rounded
  localparam int unsigned RATIO_DEN         = 100;
  localparam int unsigned RATIO_MARGIN_HIGH = 105;
  localparam int unsigned RATIO_MARGIN_LOW  = 95;
  localparam int unsigned RATIO_UPPER_LIMIT = 110;
  // one volt per ms = 8.192 lsb per us; 8389/1024 approximates 8.192
  localparam int unsigned LSB_PER_VUS_NUM   = 8389;
  localparam int          RATE_Q_SHIFT      = 6;
  // slew update tick
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned SLEW_TICK_NS      = 1000;
  localparam int unsigned SLEW_TICK_CYCLES  = SLEW_TICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  INIT_WAIT_CYCLES  = 2'h3;
  // operation byte fields
  localparam logic [1:0]  OP_UNIT_ON        = 2'h2;
  localparam logic [1:0]  OP_MARGIN_NONE    = 2'h0;
  localparam logic [1:0]  OP_MARGIN_LOW     = 2'h1;
  localparam logic [1:0]  OP_MARGIN_HIGH    = 2'h2;
endpackage
`default_nettype wire

// ===== rtl/ovs_scale.sv
`default_nettype none
module ovs_scale #(
  parameter int unsigned NUM = 100
) (
  input  wire logic [15:0] value_i,
  output logic      [15:0] scaled_o
);
  import ovs_pkg::*;
  logic [31:0] prod;
  logic [31:0] quot;
  if (NUM == 0 || NUM > 4095) begin : g_bad_ratio
    $error("ovs_scale: ratio out of range");
  end
  assign prod = 32'(value_i) * 32'(NUM);
  assign quot = prod / 32'(RATIO_DEN);
  // saturate rather than wrap on a high strap
  assign scaled_o = (quot > 32'h0000ffff) ? 16'hffff : quot[15:0];
endmodule
`default_nettype wire

// ===== rtl/ovs_slew.sv
`default_nettype none
module ovs_slew (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] target_i,
  input  wire logic        jump_i,
  input  wire logic        ramp_i,
  input  wire logic        tick_i,
  input  wire logic [31:0] step_i,
  output logic      [15:0] level_o,
  output logic             busy_o
);
  import ovs_pkg::*;
  logic [31:0] pos;
  logic [32:0] up_sum;
  logic [32:0] dn_dif;
  assign up_sum  = {1'b0, pos} + {1'b0, step_i};
  assign dn_dif  = {1'b0, pos} - {1'b0, step_i};
  assign level_o = pos[31:16];
  assign busy_o  = (pos[31:16] != target_i) || (pos[15:0] != 16'h0000);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pos <= 32'h0000_0000;
    end else if (jump_i || !ramp_i) begin
      pos <= {target_i, 16'h0000};
    end else if (tick_i) begin
      if (pos[31:16] < target_i) begin
        pos <= (up_sum[32:16] >= {1'b0, target_i}) ? {target_i, 16'h0000} : up_sum[31:0];
      end else if (busy_o) begin
        pos <= (dn_dif[32] || dn_dif[31:16] <= target_i) ? {target_i, 16'h0000} : dn_dif[31:0];
      end
    end
  end

  // between ticks a ramp holds still
  a_ramp_hold_tick: assert property (@(posedge clock_i) disable iff (rst_i)
    (ramp_i && !jump_i && !tick_i) |=> $stable(level_o))
    else $error("level moved between slew ticks");
endmodule
`default_nettype wire

// ===== bench/ovs_host_model.sv
`default_nettype none
module ovs_host_model (
  input  wire logic        clock_i,
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_err_i,
  input  wire logic [15:0] rsp_data_i,
  output var  logic        cmd_valid_o,
  output var  logic        cmd_write_o,
  output var  logic [7:0]  cmd_code_o,
  output var  logic [1:0]  cmd_bytes_o,
  output var  logic [15:0] cmd_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'hff;
    cmd_bytes_o = 2'h0;
    cmd_wdata_o = 16'hffff;
  end
  // one strobe per word; the answer is sampled while it stands, after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [1:0] nb,
                      input logic [15:0] wd, output logic ok, output logic err,
                      output logic [15:0] rd);
    @(negedge clock_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o  = code;
    cmd_bytes_o = nb;
    cmd_wdata_o = wd;
    @(negedge clock_i);
    ok  = rsp_valid_i;
    err = rsp_err_i;
    rd  = rsp_data_i;
    cmd_valid_o = 1'b0;
    // released code and data lines show the inverse so a stale word is never taken as fresh
    cmd_code_o  = ~code;
    cmd_wdata_o = ~wd;
  endtask
endmodule
`default_nettype wire

// ===== bench/ovs_setpoint_bank_test.sv
`default_nettype none
module ovs_setpoint_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ovs_pkg::*;
  logic        clock_i;
  logic        rst_i;
  logic [15:0] strap;
  logic [7:0]  op;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_code;
  logic [1:0]  cmd_bytes;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic        rsp_err;
  logic [15:0] rsp_data;
  logic [15:0] vout_ref;
  logic        unit_on;
  logic        ramp_busy;
  logic        init_done;
  int          fail_count;
  int          checked;
  int          n;
  logic [7:0]  codes [6];
  logic [15:0] expv [6];

  ovs_setpoint_bank dut (.clock_i(clock_i), .rst_i(rst_i), .strap_voltage_i(strap),
    .operation_i(op), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_code_i(cmd_code), .cmd_bytes_i(cmd_bytes), .cmd_wdata_i(cmd_wdata),
    .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data),
    .vout_ref_o(vout_ref), .unit_on_o(unit_on), .ramp_busy_o(ramp_busy),
    .init_done_o(init_done));
  ovs_host_model host (.clock_i(clock_i), .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err),
    .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_code_o(cmd_code), .cmd_bytes_o(cmd_bytes), .cmd_wdata_o(cmd_wdata));

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %b", $time, m, got);
    end
  endtask
  task automatic xact(input logic w, input logic [7:0] c, input logic [1:0] nb,
                      input logic [15:0] v, input logic exp_err, input logic [15:0] exp_d);
    logic ok;
    logic e;
    logic [15:0] d;
    host.xfer(w, c, nb, v, ok, e, d);
    chk1(ok, 1'b1, "no answer");
    chk1(e, exp_err, "error flag");
    chk16(d, exp_d, "read data");
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    xact(1'b1, c, WORD_BYTES, v, 1'b0, 16'h0000);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] x);
    xact(1'b0, c, WORD_BYTES, 16'h0000, 1'b0, x);
  endtask
  task automatic vchk(input int cyc, input logic [15:0] x);
    repeat (cyc) @(negedge clock_i);
    chk16(vout_ref, x, "vout");
  endtask
  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // the whole sequence needs well under 10000 cycles
  initial begin
    #500us;
    fail_count++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    strap = 16'h2000;
    op = 8'h00;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    xact(1'b0, CMD_TARGET_SETPT, WORD_BYTES, 16'h0000, 1'b1, 16'h0000);
    for (n = 0; n < 20 && init_done !== 1'b1; n++) @(negedge clock_i);
    chk1(init_done, 1'b1, "init done");
    codes = '{CMD_TARGET_SETPT, CMD_CAL_OFFSET, CMD_UPPER_LIMIT, CMD_MARGIN_HIGH,
              CMD_MARGIN_LOW, CMD_SLEW_RATE};
    // 0x2000 strap: limit 1.10x, high 1.05x, low 0.95x, truncated
    expv = '{strap, 16'h0000, 16'h2333, 16'h2199, 16'h1e66, 16'hba00};
    foreach (codes[i]) rd(codes[i], expv[i]);
    xact(1'b0, CMD_VOLTAGE_MODE, BYTE_BYTES, 16'h0000, 1'b0, 16'h0013);
    $display("test reset values done");
    xact(1'b1, CMD_VOLTAGE_MODE, BYTE_BYTES, 16'h5a5a, 1'b1, 16'h0000);
    xact(1'b1, CMD_TARGET_SETPT, BYTE_BYTES, 16'h5a5a, 1'b1, 16'h0000);
    xact(1'b0, CMD_MARGIN_HIGH, 2'h3, 16'h0000, 1'b1, 16'h0000);
    xact(1'b1, 8'h22, WORD_BYTES, 16'h5a5a, 1'b1, 16'h0000);
    rd(CMD_TARGET_SETPT, strap);
    $display("test refusals done");
    foreach (codes[i]) wr(codes[i], 16'h8421 + 16'(i * 16'h1111));
    foreach (codes[i]) rd(codes[i], 16'h8421 + 16'(i * 16'h1111));
    $display("test readback done");
    wr(CMD_UPPER_LIMIT, 16'h2330);
    wr(CMD_CAL_OFFSET, 16'h0000);
    wr(CMD_TARGET_SETPT, 16'h2000);
    wr(CMD_SLEW_RATE, SLEW_RATE_FASTEST);
    wr(CMD_MARGIN_HIGH, 16'h4000);
    wr(CMD_MARGIN_LOW, 16'h1f00);
    op = 8'h80;
    vchk(6, 16'h2000);
    chk1(unit_on, 1'b1, "unit on");
    wr(CMD_CAL_OFFSET, 16'h0010);
    vchk(6, 16'h2010);
    wr(CMD_CAL_OFFSET, 16'hfff0);
    vchk(6, 16'h1ff0);
    wr(CMD_CAL_OFFSET, 16'h0000);
    wr(CMD_TARGET_SETPT, 16'h3000);
    vchk(6, 16'h2330);
    rd(CMD_TARGET_SETPT, 16'h3000);
    op = 8'ha4;
    vchk(6, 16'h2330);
    wr(CMD_MARGIN_HIGH, 16'h2100);
    vchk(6, 16'h2100);
    op = 8'h94;
    vchk(6, 16'h1f00);
    chk1(ramp_busy, 1'b0, "no ramp at fastest rate");
    $display("test set points done");
    wr(CMD_TARGET_SETPT, 16'h2000);
    wr(CMD_SLEW_RATE, 16'hba00);
    op = 8'h80;
    repeat (300) @(negedge clock_i);
    chk1(ramp_busy, 1'b1, "ramp busy");
    chk1(vout_ref > 16'h1f08 && vout_ref < 16'h1f40, 1'b1, "ramp level");
    for (n = 300; n < 5000 && ramp_busy === 1'b1; n++) @(negedge clock_i);
    chk16(vout_ref, 16'h2000, "ramp end");
    chk1(n > 2800 && n < 3400, 1'b1, "ramp time");
    wr(CMD_CAL_OFFSET, 16'h0100);
    vchk(6, 16'h2100);
    wr(CMD_CAL_OFFSET, 16'h0000);
    $display("test ramp done");
    op = 8'h94;
    repeat (300) @(negedge clock_i);
    chk1(ramp_busy, 1'b1, "ramp down busy");
    op = 8'h00;
    vchk(4, 16'h0000);
    chk1(unit_on, 1'b0, "unit off");
    op = 8'h80;
    vchk(4, 16'h2000);
    $display("test on off done");
    complete_run();
  end
endmodule
`default_nettype wire
